// ---- pfg_ctrl_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// controller model: pwm, zero-cross enable and disable pins
module pfg_ctrl_model (
	// clock
	input wire logic ref_clk,
	// pin comparator levels
	output logic pwm_above_hi,
	output logic pwm_below_lo,
	output logic zce_above_hi,
	output logic zce_below_lo,
	output logic stage_disable_n
);
	// idle: enabled, forced ccm, pwm low
	initial begin
		pwm_above_hi = 1'b0;
		pwm_below_lo = 1'b1;
		zce_above_hi = 1'b1;
		zce_below_lo = 1'b0;
		stage_disable_n = 1'b1;
	end
	// levels: 0 low, 1 high, 2 tri-state band
	task automatic set_lvl(input bit d, input int z, input int p);
		@(posedge ref_clk);
		stage_disable_n <= d;
		zce_above_hi <= (z == 1);
		zce_below_lo <= (z == 0);
		pwm_above_hi <= (p == 1);
		pwm_below_lo <= (p == 0);
	endtask
	// one switching period, high half then low half
	task automatic cycle(input int n);
		set_lvl(1'b1, 1, 1);
		repeat (n) @(posedge ref_clk);
		set_lvl(1'b1, 1, 0);
		repeat (n) @(posedge ref_clk);
	endtask
	// low pulse long enough to cross the synchroniser
	task automatic pulse_disable();
		@(posedge ref_clk);
		stage_disable_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		stage_disable_n <= 1'b1;
	endtask
endmodule

// ---- pfg_pkg.sv ----
// ==========================================================
// types used by the gate sequencer logic
package pfg_pkg;
	// gate sequencer, one-hot
	typedef enum logic [2:0] {
		GS_OFF = 3'h1,
		GS_HIGH = 3'h2,
		GS_LOW = 3'h4
	} pfg_gate_state_t;
endpackage

// ---- pfg_regs.svh ----
`ifndef PFG_REGS_SVH
`define PFG_REGS_SVH
// ==========================================================
// register map, byte addresses on the wishbone bus
`define PFG_ADDR_CTRL 4'h0
`define PFG_ADDR_STATUS 4'h4
`define PFG_ADDR_COUNT 4'h8
// control fields and reset value
`define PFG_CTRL_FOLD_BIT 0
`define PFG_CTRL_FORCE_BIT 1
`define PFG_CTRL_RESET 2'h1
// status fields
`define PFG_ST_WARN_BIT 0
`define PFG_ST_SHDN_BIT 1
`define PFG_ST_OC_BIT 2
`define PFG_ST_BOOT_BIT 3
`define PFG_ST_SHORT_BIT 4
`define PFG_ST_FAULT_BIT 5
`define PFG_ST_HG_BIT 6
`define PFG_ST_LG_BIT 7
// count register fields
`define PFG_CNT_CLEAN_LSB 0
`define PFG_CNT_SHORT_LSB 8
// ==========================================================
// synchronised pin vector layout
`define PFG_SYNC_W 14
`define PFG_IN_PWM_HI 0
`define PFG_IN_PWM_LO 1
`define PFG_IN_ZCE_HI 2
`define PFG_IN_ZCE_LO 3
`define PFG_IN_DIS_N 4
`define PFG_IN_T_WARN 5
`define PFG_IN_T_HYST 6
`define PFG_IN_T_SHDN 7
`define PFG_IN_BOOT 8
`define PFG_IN_OC 9
`define PFG_IN_SHORT 10
`define PFG_IN_IL_POS 11
`define PFG_IN_HG_OFF 12
`define PFG_IN_LG_OFF 13
// ==========================================================
// timing and counts
`define PFG_CLK_KHZ 10000
`define PFG_TSHO_NS 30
`define PFG_OC_CLEAN_CYC 128
`define PFG_SHORT_CYC 4
`endif

// ---- pfg_sync.sv ----
`timescale 1ns/100ps
// ==========================================================
// two-flop synchroniser bank for all asynchronous pins
module pfg_sync #(
	parameter int W = 14
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// pin levels
	pfg_sync_if.sync pins
);
	logic [W-1:0] meta_reg; // first stage, read only by second
	logic [W-1:0] sync_reg; // second stage

	initial begin
		if (W < 1) $error("pfg_sync: width must be positive");
	end

	// both stages, nothing else taps the first one
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= pins.raw;
			sync_reg <= meta_reg;
		end
	end

	assign pins.synced = sync_reg;
endmodule

// ---- pfg_sync_if.sv ----
`timescale 1ns/100ps
// ==========================================================
// raw pin levels in, synchronised levels out
interface pfg_sync_if #(parameter int W = 14);
	logic [W-1:0] raw; // straight from the pins
	logic [W-1:0] synced; // safe for logic on ref_clk
	modport src (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

// ---- pfg_top.sv ----
`timescale 1ns/100ps
`include "pfg_regs.svh"
module pfg_top #(
	parameter int CLEAN_CYC = `PFG_OC_CLEAN_CYC,
	parameter int SHORT_CYC = `PFG_SHORT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// controller pins, comparator levels
	input wire logic pwm_above_hi,
	input wire logic pwm_below_lo,
	input wire logic zce_above_hi,
	input wire logic zce_below_lo,
	input wire logic stage_disable_n,
	// analog monitor comparators
	input wire logic temp_above_warn,
	input wire logic temp_below_hyst,
	input wire logic temp_above_shdn,
	input wire logic boot_supply_low,
	input wire logic over_current,
	input wire logic phase_short_seen,
	input wire logic inductor_current_pos,
	input wire logic high_gate_sensed_off,
	input wire logic low_gate_sensed_off,
	// gate commands and flag
	output logic high_gate_drive,
	output logic low_gate_drive,
	output logic fault_report_out,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ==========================================================
	// derived constants
	localparam int TSHO_CYC_RAW =
		(`PFG_TSHO_NS * `PFG_CLK_KHZ + 999999) / 1000000;
	localparam int TSHO_CYC = (TSHO_CYC_RAW < 1) ? 1 : TSHO_CYC_RAW;
	localparam logic [7:0] CLEAN_LAST = 8'(CLEAN_CYC - 1);
	localparam logic [2:0] SHORT_LAST = 3'(SHORT_CYC - 1);
	localparam logic [3:0] TSHO_LIM = 4'(TSHO_CYC);

	initial begin
		if (CLEAN_CYC < 2 || CLEAN_CYC > 255)
			$error("pfg_top: CLEAN_CYC out of range");
		if (SHORT_CYC < 1 || SHORT_CYC > 7)
			$error("pfg_top: SHORT_CYC out of range");
		if (TSHO_CYC > 15)
			$error("pfg_top: hold-off too long for counter");
	end

	// rising edge of a level against its delayed copy
	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// ==========================================================
	// pin synchronisation
	pfg_sync_if #(.W(`PFG_SYNC_W)) pins ();
	logic [`PFG_SYNC_W-1:0] s; // synchronised pins

	assign pins.raw = {low_gate_sensed_off, high_gate_sensed_off,
		inductor_current_pos, phase_short_seen, over_current,
		boot_supply_low, temp_above_shdn, temp_below_hyst,
		temp_above_warn, stage_disable_n, zce_below_lo,
		zce_above_hi, pwm_below_lo, pwm_above_hi};
	assign s = pins.synced;

	pfg_sync #(.W(`PFG_SYNC_W)) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pins(pins)
	);

	// ==========================================================
	// decoded pin states
	wire pwm_hi = s[`PFG_IN_PWM_HI];
	wire pwm_lo = s[`PFG_IN_PWM_LO] & ~pwm_hi;
	wire pwm_tri = ~s[`PFG_IN_PWM_HI] & ~s[`PFG_IN_PWM_LO];
	wire zce_tri = ~s[`PFG_IN_ZCE_HI] & ~s[`PFG_IN_ZCE_LO];
	wire zce_diode = s[`PFG_IN_ZCE_LO] & ~s[`PFG_IN_ZCE_HI];
	wire dis_n = s[`PFG_IN_DIS_N];
	wire oc_now = s[`PFG_IN_OC];
	wire short_now = s[`PFG_IN_SHORT];

	logic pwm_hi_d_reg; // delayed pwm high, cycle marker
	logic dis_n_d_reg; // delayed disable level
	// switching cycle boundary on each new high pulse
	wire cycle_end = rise(pwm_hi, pwm_hi_d_reg);
	// disable going low counts as the toggle
	wire dis_fall = rise(dis_n_d_reg, dis_n);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pwm_hi_d_reg <= 1'b0;
			dis_n_d_reg <= 1'b0;
		end else begin
			pwm_hi_d_reg <= pwm_hi;
			dis_n_d_reg <= dis_n;
		end
	end

	// ==========================================================
	// control register
	logic [1:0] ctrl_reg; // fold enable, software force off
	wire fold_en = ctrl_reg[`PFG_CTRL_FOLD_BIT];
	wire force_off = ctrl_reg[`PFG_CTRL_FORCE_BIT];

	// ==========================================================
	// thermal warning and shutdown
	logic warn_reg; // above warning threshold
	logic shdn_reg; // shutdown latch
	// set wins over the hysteresis release
	wire warn_next = s[`PFG_IN_T_WARN] ? 1'b1 :
		(s[`PFG_IN_T_HYST] ? 1'b0 : warn_reg);
	// only a disable toggle clears it, an over-temp set wins
	wire shdn_next = s[`PFG_IN_T_SHDN] ? 1'b1 :
		(dis_fall ? 1'b0 : shdn_reg);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			warn_reg <= 1'b0;
			shdn_reg <= 1'b0;
		end else begin
			warn_reg <= warn_next;
			shdn_reg <= shdn_next;
		end
	end

	// ==========================================================
	// over-current fault with clean cycle count
	logic oc_reg; // over-current fault flag
	logic oc_seen_reg; // protection fired in current cycle
	logic [7:0] clean_reg; // clean cycles since last event
	logic skip_reg; // skip next high pulse to fold frequency
	wire oc_cycle = oc_seen_reg | oc_now;
	wire clean_done = cycle_end & ~oc_cycle & (clean_reg == CLEAN_LAST);
	wire oc_next = oc_now ? 1'b1 : (clean_done ? 1'b0 : oc_reg);
	// a boundary closing a cycle that saw the limit restarts the count,
	// so only cycles that are clean from start to end are counted
	wire [7:0] clean_next = oc_now ? 8'h00 :
		(~(cycle_end & oc_reg) ? clean_reg :
		(oc_cycle ? 8'h00 : 8'(clean_reg + 8'h01)));
	// one skipped pulse per cycle that saw the limit
	wire skip_next = cycle_end ? (oc_cycle & fold_en) : skip_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			oc_reg <= 1'b0;
			oc_seen_reg <= 1'b0;
			clean_reg <= 8'h00;
			skip_reg <= 1'b0;
		end else begin
			oc_reg <= oc_next;
			oc_seen_reg <= cycle_end ? oc_now : oc_cycle;
			clean_reg <= clean_done ? 8'h00 : clean_next;
			skip_reg <= skip_next;
		end
	end

	// ==========================================================
	// high-side short detection
	logic short_reg; // latched short, only reset clears it
	logic short_seen_reg; // short sampled in current cycle
	logic [2:0] short_cnt_reg; // consecutive short cycles
	wire short_cycle = short_seen_reg | short_now;
	wire short_hit = cycle_end & short_cycle & ~short_reg;
	wire short_latch = short_hit & (short_cnt_reg == SHORT_LAST);
	wire [2:0] short_cnt_next = ~cycle_end | short_reg ? short_cnt_reg :
		(short_cycle ? 3'(short_cnt_reg + 3'h1) : 3'h0);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			short_reg <= 1'b0;
			short_seen_reg <= 1'b0;
			short_cnt_reg <= 3'h0;
		end else begin
			// no clear path besides reset, disable is ignored
			short_reg <= short_reg | short_latch;
			short_seen_reg <= cycle_end ? short_now : short_cycle;
			short_cnt_reg <= short_cnt_next;
		end
	end

	// ==========================================================
	// fault flag
	wire [4:0] src = {short_reg, s[`PFG_IN_BOOT], oc_reg, shdn_reg,
		warn_reg};
	wire src_any = |src;
	logic fault_reg; // registered flag pin

	always_ff @(posedge ref_clk) begin
		if (reset) fault_reg <= 1'b0;
		else fault_reg <= src_any;
	end
	assign fault_report_out = fault_reg;

	// ==========================================================
	// tri-state hold-off
	logic [3:0] tri_cnt_reg; // cycles spent in tri-state band
	wire tri_hold = pwm_tri & (tri_cnt_reg >= TSHO_LIM);

	always_ff @(posedge ref_clk) begin
		if (reset) tri_cnt_reg <= 4'h0;
		else if (!pwm_tri) tri_cnt_reg <= 4'h0;
		else if (!tri_hold) tri_cnt_reg <= 4'(tri_cnt_reg + 4'h1);
	end

	// ==========================================================
	// gate request decode
	// a short band before hold-off expires drops both requests, pwm_hi and pwm_lo are both low
	wire stop_all = ~dis_n | zce_tri | shdn_reg | force_off;
	wire lo_ok = ~zce_diode | s[`PFG_IN_IL_POS];
	wire want_hi_n = pwm_hi & ~oc_now & ~skip_reg;
	wire want_lo_n = pwm_lo & lo_ok;
	wire want_hi = ~short_reg & ~stop_all & ~tri_hold & want_hi_n;
	// latched short overrides pwm and parks the low side on
	wire want_lo = short_reg |
		(~stop_all & ~tri_hold & want_lo_n);

	// ==========================================================
	// gate sequencer, break before make
	pfg_pkg::pfg_gate_state_t gate_reg; // present gate state
	pfg_pkg::pfg_gate_state_t gate_next; // next gate state

	// a gate turns on only from off with the other sensed low
	always_comb begin
		gate_next = gate_reg;
		case (gate_reg)
			pfg_pkg::GS_OFF: begin
				if (want_hi && s[`PFG_IN_LG_OFF]) begin
					gate_next = pfg_pkg::GS_HIGH;
				end else if (want_lo && s[`PFG_IN_HG_OFF]) begin
					gate_next = pfg_pkg::GS_LOW;
				end
			end
			pfg_pkg::GS_HIGH: begin
				if (!want_hi) gate_next = pfg_pkg::GS_OFF;
			end
			pfg_pkg::GS_LOW: begin
				if (!want_lo) gate_next = pfg_pkg::GS_OFF;
			end
			default: begin
				gate_next = pfg_pkg::GS_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) gate_reg <= pfg_pkg::GS_OFF;
		else gate_reg <= gate_next;
	end

	assign high_gate_drive = (gate_reg == pfg_pkg::GS_HIGH);
	assign low_gate_drive = (gate_reg == pfg_pkg::GS_LOW);

	// ==========================================================
	// wishbone slave, one wait state, unmapped reads zero
	logic ack_reg; // answer strobe
	logic [31:0] rdat_reg; // registered read data
	wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire hit_ctrl = (wb_adr_i == `PFG_ADDR_CTRL);
	wire hit_status = (wb_adr_i == `PFG_ADDR_STATUS);
	wire hit_count = (wb_adr_i == `PFG_ADDR_COUNT);
	wire ctrl_wr = req & wb_we_i & hit_ctrl & wb_sel_i[0];
	wire [7:0] status_v = {low_gate_drive, high_gate_drive, fault_reg,
		short_reg, s[`PFG_IN_BOOT], oc_reg, shdn_reg, warn_reg};
	wire [31:0] count_v = (32'(short_cnt_reg) << `PFG_CNT_SHORT_LSB) |
		(32'(clean_reg) << `PFG_CNT_CLEAN_LSB);
	wire [31:0] rdat_next = hit_ctrl ? 32'(ctrl_reg) :
		hit_status ? 32'(status_v) : hit_count ? count_v : 32'h0;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
			ctrl_reg <= `PFG_CTRL_RESET;
		end else begin
			ack_reg <= req;
			if (req) rdat_reg <= rdat_next;
			if (ctrl_wr) ctrl_reg <= wb_dat_i[1:0];
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_tri_held;
		pwm_tri [*3];
	endsequence
	sequence s_last_short;
		short_cnt_reg == SHORT_LAST && short_hit;
	endsequence

	a_gates_exclusive: assert property (
		!(high_gate_drive && low_gate_drive))
		else $error("both gates on");
	a_fault_follows: assert property (
		src_any |=> fault_report_out) else $error("fault not reported");
	a_fault_quiet: assert property (
		!src_any |=> !fault_report_out) else $error("spurious fault");
	// a latched short keeps the low side parked on even in the band
	a_tri_off: assert property (s_tri_held |->
		!high_gate_drive && (short_reg || !low_gate_drive))
		else $error("tri not off");
	a_short_latch: assert property (
		s_last_short |=> short_reg ##1 fault_report_out)
		else $error("short not latched");
	a_short_sticky: assert property (
		short_reg |=> short_reg) else $error("short flag dropped");
	a_short_lowon: assert property (
		short_reg && s[`PFG_IN_HG_OFF] |-> ##[0:2] low_gate_drive)
		else $error("low gate not held on");
	a_short_zero: assert property (
		cycle_end && !short_cycle && !short_reg |=> short_cnt_reg == 3'h0)
		else $error("short count not zeroed");
	a_shdn_stop: assert property (
		shdn_reg |=> !high_gate_drive) else $error("switching in shutdown");
	a_shdn_hold: assert property (
		shdn_reg && !dis_fall |=> shdn_reg) else $error("shutdown lost");
	a_oc_clear: assert property (
		oc_reg && clean_done && !oc_now |=> !oc_reg)
		else $error("oc not cleared");
	a_oc_cut: assert property (
		oc_now && high_gate_drive |=> !high_gate_drive)
		else $error("on-time not cut");
	a_warn_set: assert property (
		s[`PFG_IN_T_WARN] |=> warn_reg) else $error("warning missed");
	// disable does not release a latched short, see the short logic
	a_disable_off: assert property (
		!dis_n && !short_reg |=> !high_gate_drive && !low_gate_drive)
		else $error("gates on while disabled");
endmodule

// ---- power_stage_fault_gate_logic_bench.sv ----
`timescale 1ns/100ps
`include "pfg_regs.svh"
// compare helper, a mismatch prints time, got and expected value
`define CHK(g, e) check_val(32'(g), 32'(e))
// ==========================================================
// bench for gate decode and fault flag
module power_stage_fault_gate_logic_bench;
	localparam int CLEAN = 128; // clean cycles that clear over-current
	localparam int LIMIT = 6000; // hang ceiling, run needs about 1700
	logic ref_clk, reset;
	logic sense_stuck; // holds the low gate sensed on
	logic [3:0] sel_req; // byte lanes for the next bus cycle
	logic pwm_above_hi, pwm_below_lo, zce_above_hi, zce_below_lo;
	logic stage_disable_n, temp_above_warn, temp_below_hyst;
	logic temp_above_shdn, boot_supply_low, over_current;
	logic phase_short_seen, inductor_current_pos;
	logic high_gate_sensed_off, low_gate_sensed_off;
	logic high_gate_drive, low_gate_drive, fault_report_out;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// ==========================================================
	// design and controller model
	pfg_top #(.CLEAN_CYC(CLEAN), .SHORT_CYC(4)) DUT (
		.ref_clk(ref_clk), .reset(reset),
		.pwm_above_hi(pwm_above_hi), .pwm_below_lo(pwm_below_lo),
		.zce_above_hi(zce_above_hi), .zce_below_lo(zce_below_lo),
		.stage_disable_n(stage_disable_n),
		.temp_above_warn(temp_above_warn),
		.temp_below_hyst(temp_below_hyst),
		.temp_above_shdn(temp_above_shdn),
		.boot_supply_low(boot_supply_low), .over_current(over_current),
		.phase_short_seen(phase_short_seen),
		.inductor_current_pos(inductor_current_pos),
		.high_gate_sensed_off(high_gate_sensed_off),
		.low_gate_sensed_off(low_gate_sensed_off),
		.high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
		.fault_report_out(fault_report_out),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
	);
	pfg_ctrl_model ctl (
		.ref_clk(ref_clk),
		.pwm_above_hi(pwm_above_hi), .pwm_below_lo(pwm_below_lo),
		.zce_above_hi(zce_above_hi), .zce_below_lo(zce_below_lo),
		.stage_disable_n(stage_disable_n)
	);
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// shared tasks
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// reset also stands in for a logic power cycle
	task automatic do_reset();
		@(posedge ref_clk);
		reset <= 1'b1;
		tick(20);
		reset <= 1'b0;
	endtask
	// classic single wishbone cycle; waits on ack, hang limit cuts it
	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel_req;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// gate sense echo, overlap watch and hang limit
	always @(posedge ref_clk) begin
		high_gate_sensed_off <= !high_gate_drive;
		low_gate_sensed_off <= !low_gate_drive && !sense_stuck;
		cycles <= cycles + 1;
		if (high_gate_drive === 1'b1 && low_gate_drive === 1'b1) begin
			`CHK(low_gate_drive, 1'b0);
		end
		if (cycles == LIMIT) begin
			n_errors++;
			stop_test();
		end
	end
	// ==========================================================
	// scenarios
	task automatic t_reset();
		tick(3);
		`CHK({high_gate_drive, low_gate_drive, fault_report_out}, 3'h0);
		wb(1'b0, `PFG_ADDR_CTRL, 32'h0);
		`CHK(rd, `PFG_CTRL_RESET);
		// unmapped place: write dropped, reads zero
		wb(1'b1, 4'hC, 32'hFFFF_FFFF);
		wb(1'b0, 4'hC, 32'h0);
		`CHK(rd, 32'h0);
	endtask
	// every disable, zce, pwm and current-sign combination
	task automatic t_decode();
		logic hg, lg;
		for (int d = 0; d < 2; d++) begin
			for (int z = 0; z < 3; z++) begin
				for (int p = 0; p < 3; p++) begin
					for (int i = 0; i < 2; i++) begin
						hg = (d == 1 && z != 2 && p == 1);
						lg = (d == 1 && z != 2 && p == 0 && (z == 1 || i == 1));
						inductor_current_pos <= i[0];
						ctl.set_lvl(d[0], z, p);
						tick(8);
						`CHK(high_gate_drive, hg);
						`CHK(low_gate_drive, lg);
					end
				end
			end
		end
	endtask
	// force-off bit, read-only status
	task automatic t_regs();
		// control write without its low byte lane is dropped
		sel_req = 4'hE;
		wb(1'b1, `PFG_ADDR_CTRL, 32'h3);
		sel_req = 4'hF;
		wb(1'b0, `PFG_ADDR_CTRL, 32'h0);
		`CHK(rd, `PFG_CTRL_RESET);
		ctl.set_lvl(1'b1, 1, 1);
		wb(1'b1, `PFG_ADDR_CTRL, 32'h3);
		tick(8);
		`CHK(high_gate_drive, 1'b0);
		wb(1'b0, `PFG_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h3);
		wb(1'b1, `PFG_ADDR_STATUS, 32'hFFFF_FFFF);
		wb(1'b0, `PFG_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0);
		wb(1'b1, `PFG_ADDR_CTRL, 32'h1);
		tick(8);
		`CHK({high_gate_drive, low_gate_drive}, 2'h2);
	endtask
	// warning with hysteresis, overlapped by bootstrap low
	task automatic t_warn();
		ctl.set_lvl(1'b1, 1, 0);
		temp_above_warn <= 1'b1;
		tick(6);
		`CHK(fault_report_out, 1'b1);
		wb(1'b0, `PFG_ADDR_STATUS, 32'h0);
		`CHK(rd[`PFG_ST_WARN_BIT], 1'b1);
		temp_above_warn <= 1'b0;
		tick(6);
		`CHK(fault_report_out, 1'b1);
		boot_supply_low <= 1'b1;
		temp_below_hyst <= 1'b1;
		tick(6);
		`CHK(fault_report_out, 1'b1);
		boot_supply_low <= 1'b0;
		tick(6);
		`CHK(fault_report_out, 1'b0);
		temp_below_hyst <= 1'b0;
	endtask
	// shutdown holds after cooling until disable is cycled
	task automatic t_shdn();
		// low gate still sensed on: high side must wait
		sense_stuck <= 1'b1;
		ctl.set_lvl(1'b1, 1, 1);
		tick(8);
		`CHK(high_gate_drive, 1'b0);
		sense_stuck <= 1'b0;
		tick(8);
		`CHK(high_gate_drive, 1'b1);
		temp_above_shdn <= 1'b1;
		tick(6);
		`CHK(high_gate_drive, 1'b0);
		temp_above_shdn <= 1'b0;
		tick(8);
		`CHK(high_gate_drive, 1'b0);
		wb(1'b0, `PFG_ADDR_STATUS, 32'h0);
		`CHK(rd[`PFG_ST_SHDN_BIT], 1'b1);
		ctl.pulse_disable();
		tick(8);
		`CHK(high_gate_drive, 1'b1);
	endtask
	// over-current cuts high side, flag clears after clean cycles
	task automatic t_oc();
		ctl.set_lvl(1'b1, 1, 0);
		over_current <= 1'b1;
		ctl.set_lvl(1'b1, 1, 1);
		tick(8);
		`CHK(high_gate_drive, 1'b0);
		`CHK(fault_report_out, 1'b1);
		over_current <= 1'b0;
		// first boundary after the event: its high pulse is skipped
		ctl.cycle(3);
		ctl.set_lvl(1'b1, 1, 1);
		tick(9);
		`CHK(high_gate_drive, 1'b0);
		ctl.set_lvl(1'b1, 1, 0);
		tick(3);
		// boundaries 2 to 125, then 126 to 128: still flagged
		repeat (CLEAN - 4) ctl.cycle(3);
		`CHK(fault_report_out, 1'b1);
		repeat (3) ctl.cycle(3);
		`CHK(fault_report_out, 1'b1);
		// boundary 129 closes the 128th clean cycle
		repeat (3) ctl.cycle(3);
		`CHK(fault_report_out, 1'b0);
	endtask
	// broken short runs never latch; a long run latches until reset
	task automatic t_short();
		for (int k = 0; k < 2; k++) begin
			phase_short_seen <= 1'b1;
			repeat (2) ctl.cycle(3);
			phase_short_seen <= 1'b0;
			repeat (2) ctl.cycle(3);
		end
		`CHK(fault_report_out, 1'b0);
		phase_short_seen <= 1'b1;
		repeat (6) ctl.cycle(3);
		`CHK(fault_report_out, 1'b1);
		ctl.set_lvl(1'b1, 1, 1);
		tick(8);
		`CHK(high_gate_drive, 1'b0);
		`CHK(low_gate_drive, 1'b1);
		phase_short_seen <= 1'b0;
		ctl.pulse_disable();
		repeat (3) ctl.cycle(3);
		`CHK(fault_report_out, 1'b1);
		do_reset();
		tick(4);
		`CHK(fault_report_out, 1'b0);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		reset = 1'b1;
		sense_stuck = 1'b0;
		sel_req = 4'hF;
		temp_above_warn = 1'b0;
		temp_below_hyst = 1'b0;
		temp_above_shdn = 1'b0;
		boot_supply_low = 1'b0;
		over_current = 1'b0;
		phase_short_seen = 1'b0;
		inductor_current_pos = 1'b1;
		high_gate_sensed_off = 1'b1;
		low_gate_sensed_off = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		do_reset();
		t_reset();
		t_decode();
		t_regs();
		t_warn();
		t_shdn();
		t_oc();
		t_short();
		stop_test();
	end
endmodule
